// *** verilog/acfg_top.v ***
// How it works
// - Select low makes the four config pins a serial register port.
// - Select high makes chip select, clock and data static mode straps.
// - Data shifts in only while chip select is low for the transfer.
// - Serial data is sampled on each rising serial clock edge.
// - Readback drives open-drain low-active data, changing after falling clock edges.
// - Strapped mode: chip select low disables stabilizer, high enables it.
// - Strapped mode: clock pin low gives full-rate CMOS, high DDR LVDS 3.5mA.
// - Strapped mode: data pin low runs normally, high enters sleep.
// - A conversion starts on each rising edge of the positive encode input.
// - Full-rate CMOS puts fourteen sample bits out in parallel, bit 13 MSB.
// - Full-rate outputs change with the falling output clock edge unless delayed.
// - DDR outputs change on both output clock edges unless delayed.
// - DDR drives even bits while output clock low, odd bits while high.
// - DDR pairs bit 2k with 2k+1 on each of seven lines.
// - CMOS modes drive negative output clock as the positive one inverted.
// - Output clock phase can be delayed by a register setting.
// - Range flag is high for any sample that overflowed or underflowed.
// - LVDS current is selectable and internal termination optionally enabled.
`timescale 1ns/1ns
`include "acfg_defs.vh"
module acfg_top (
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // Configuration pins
   input wire programming_select,
   input wire cs_n,
   input wire sck,
   input wire sdi,
   input wire sdo_in,
   output reg sdo_out_q,
   output reg sdo_oe_q,
   // Encode and converter core
   input wire encode_pos,
   input wire encode_neg,
   input wire [`ACFG_SAMPLE_W-1:0] core_sample,
   input wire core_range,
   // Sample outputs
   output reg [`ACFG_SAMPLE_W-1:0] sample_bits_q,
   output reg [`ACFG_PAIR_N-1:0] ddr_pair_lines_q,
   output reg range_flag_q,
   output reg output_clock_pos_q,
   output reg output_clock_neg_q,
   // Settings seen by the analog side
   output reg [1:0] out_mode_q,
   output reg dcs_enable_q,
   output reg sleep_q,
   output reg [2:0] lvds_current_q,
   output reg lvds_term_q
);
   // Input synchronisers
   reg [1:0] sel_s_q, cs_s_q, sck_s_q, sdi_s_q, encp_s_q, encn_s_q;
   reg sck_d1_q, encp_d1_q;
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sel_s_q <= 2'h0;
         cs_s_q <= 2'h3;
         sck_s_q <= 2'h0;
         sdi_s_q <= 2'h0;
         encp_s_q <= 2'h0;
         encn_s_q <= 2'h3;
         sck_d1_q <= 1'b0;
         encp_d1_q <= 1'b0;
      end else begin
         sel_s_q <= {sel_s_q[0], programming_select};
         cs_s_q <= {cs_s_q[0], cs_n};
         sck_s_q <= {sck_s_q[0], sck};
         sdi_s_q <= {sdi_s_q[0], sdi};
         encp_s_q <= {encp_s_q[0], encode_pos};
         encn_s_q <= {encn_s_q[0], encode_neg};
         sck_d1_q <= sck_s_q[1];
         encp_d1_q <= encp_s_q[1];
      end
   end
   wire par_mode = sel_s_q[1];
   wire ser_mode = !sel_s_q[1];
   wire cs_low = ser_mode && !cs_s_q[1];
   wire sck_rise = sck_s_q[1] && !sck_d1_q;
   wire sck_fall = !sck_s_q[1] && sck_d1_q;
   // Encode level is taken from the positive input alone; the negative input is unused
   wire enc_level = encp_s_q[1];
   wire conv_start = enc_level && !encp_d1_q;
   wire unused_encn = encn_s_q[1];

   // Serial frame shifter
   reg [`ACFG_FRAME_W-1:0] shift_q;
   reg [`ACFG_BIT_CNT_W-1:0] bit_cnt_q;
   reg rd_frame_q;
   reg wr_en_q;
   reg [`ACFG_REG_AW-1:0] wr_addr_q;
   reg [`ACFG_DATA_W-1:0] wr_data_q;
   reg [`ACFG_DATA_W-1:0] rd_shift_q;
   reg load_rd_q;
   wire [`ACFG_FRAME_W-1:0] shift_next = {shift_q[`ACFG_FRAME_W-2:0], sdi_s_q[1]};
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         shift_q <= {`ACFG_FRAME_W{1'b0}};
         bit_cnt_q <= {`ACFG_BIT_CNT_W{1'b0}};
         rd_frame_q <= 1'b0;
         wr_en_q <= 1'b0;
         wr_addr_q <= {`ACFG_REG_AW{1'b0}};
         wr_data_q <= {`ACFG_DATA_W{1'b0}};
         load_rd_q <= 1'b0;
      end else begin
         wr_en_q <= 1'b0;
         load_rd_q <= 1'b0;
         if (!cs_low) begin
            bit_cnt_q <= {`ACFG_BIT_CNT_W{1'b0}};
            rd_frame_q <= 1'b0;
         end else if (sck_rise && bit_cnt_q <= `ACFG_BIT_LAST) begin
            shift_q <= shift_next;
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q == 5'h00) begin
               rd_frame_q <= sdi_s_q[1];
            end
            if (bit_cnt_q == `ACFG_BIT_DATA0 - 5'h01) begin
               wr_addr_q <= shift_next[`ACFG_REG_AW-1:0];
               load_rd_q <= 1'b1;
            end
            if (bit_cnt_q == `ACFG_BIT_LAST && !shift_next[`ACFG_RW_BIT]) begin
               wr_en_q <= 1'b1;
               wr_data_q <= shift_next[`ACFG_DATA_W-1:0];
            end
         end
      end
   end
   wire unused_addr = shift_q[`ACFG_ADDR_MSB] | shift_q[`ACFG_ADDR_LSB+`ACFG_REG_AW];

   // Register file
   wire [`ACFG_DATA_W-1:0] rd_data;
   wire [`ACFG_REG_N*`ACFG_DATA_W-1:0] regs_flat;
   wire soft_reset = wr_en_q && wr_addr_q == `ACFG_REG_RESET && wr_data_q[`ACFG_F_SOFT_RESET];
   acfg_regfile u_regs (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .wr_en(wr_en_q && !soft_reset),
      .wr_addr(wr_addr_q),
      .wr_data(wr_data_q),
      .clear_all(soft_reset || par_mode),
      .rd_addr(wr_addr_q),
      .rd_data_q(rd_data),
      .regs_flat(regs_flat)
   );
   wire [`ACFG_DATA_W-1:0] reg_power = regs_flat[`ACFG_REG_POWER*`ACFG_DATA_W +: `ACFG_DATA_W];
   wire [`ACFG_DATA_W-1:0] reg_timing = regs_flat[`ACFG_REG_TIMING*`ACFG_DATA_W +: `ACFG_DATA_W];
   wire [`ACFG_DATA_W-1:0] reg_outmode = regs_flat[`ACFG_REG_OUTMODE*`ACFG_DATA_W +: `ACFG_DATA_W];

   // Readback: open-drain, low drives zero, changes after falling edges
   reg rd_armed_q;
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_shift_q <= {`ACFG_DATA_W{1'b0}};
         rd_armed_q <= 1'b0;
         sdo_out_q <= 1'b0;
         sdo_oe_q <= 1'b0;
      end else if (!cs_low || !rd_frame_q) begin
         rd_armed_q <= 1'b0;
         sdo_out_q <= 1'b0;
         sdo_oe_q <= 1'b0;
      end else begin
         // Wait one cycle after the address lands so the registered read data is fresh
         if (bit_cnt_q == `ACFG_BIT_DATA0 && !rd_armed_q && !load_rd_q) begin
            rd_shift_q <= rd_data;
            rd_armed_q <= 1'b1;
         end else if (sck_fall && rd_armed_q) begin
            sdo_out_q <= 1'b0;
            sdo_oe_q <= !rd_shift_q[`ACFG_DATA_W-1];
            rd_shift_q <= {rd_shift_q[`ACFG_DATA_W-2:0], 1'b1};
         end
      end
   end
   wire unused_sdo = sdo_in | load_rd_q | unused_addr | unused_encn;

   // Effective settings
   reg [1:0] mode_d;
   reg dcs_d, sleep_d, term_d;
   reg [2:0] cur_d;
   reg [1:0] phase_d;
   always @* begin
      if (par_mode) begin
         dcs_d = cs_s_q[1];
         mode_d = sck_s_q[1] ? `ACFG_MODE_DDR_LVDS : `ACFG_MODE_CMOS;
         cur_d = `ACFG_ILVDS_3P5;
         sleep_d = sdi_s_q[1];
         term_d = 1'b0;
         phase_d = `ACFG_PHASE_0;
      end else begin
         dcs_d = reg_timing[`ACFG_F_DCS];
         mode_d = reg_outmode[`ACFG_F_MODE_MSB:`ACFG_F_MODE_LSB];
         cur_d = reg_outmode[`ACFG_F_ILVDS_MSB:`ACFG_F_ILVDS_LSB];
         sleep_d = reg_power[`ACFG_F_SLEEP];
         term_d = reg_outmode[`ACFG_F_TERM];
         phase_d = reg_timing[`ACFG_F_PHASE_MSB:`ACFG_F_PHASE_LSB];
      end
   end
   reg [1:0] phase_q;
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_mode_q <= `ACFG_MODE_CMOS;
         dcs_enable_q <= 1'b0;
         sleep_q <= 1'b0;
         lvds_current_q <= `ACFG_ILVDS_3P5;
         lvds_term_q <= 1'b0;
         phase_q <= `ACFG_PHASE_0;
      end else begin
         out_mode_q <= (mode_d == `ACFG_MODE_DDR_LVDS) ? mode_d :
            (mode_d == `ACFG_MODE_DDR_CMOS) ? mode_d : `ACFG_MODE_CMOS;
         dcs_enable_q <= dcs_d;
         sleep_q <= sleep_d;
         lvds_current_q <= cur_d;
         lvds_term_q <= term_d;
         phase_q <= phase_d;
      end
   end

   // Sample capture and output formatting
   reg [`ACFG_SAMPLE_W-1:0] held_q;
   reg held_rng_q;
   reg [1:0] ph_hist_q;
   wire enc_fall = !enc_level && encp_d1_q;
   wire is_ddr = out_mode_q != `ACFG_MODE_CMOS;
   wire [`ACFG_PAIR_N-1:0] even_bits, odd_bits;
   genvar gk;
   generate
      for (gk = 0; gk < `ACFG_PAIR_N; gk = gk + 1) begin : g_pair
         assign even_bits[gk] = held_q[2*gk];
         assign odd_bits[gk] = held_q[2*gk+1];
      end
   endgenerate
   // Delayed clock: phase code selects a 0..3 cycle lag of the encode level
   reg [2:0] enc_hist_q;
   wire clk_src = (phase_q == `ACFG_PHASE_0) ? enc_level : enc_hist_q[phase_q - 2'h1];
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         held_q <= {`ACFG_SAMPLE_W{1'b0}};
         held_rng_q <= 1'b0;
         sample_bits_q <= {`ACFG_SAMPLE_W{1'b0}};
         ddr_pair_lines_q <= {`ACFG_PAIR_N{1'b0}};
         range_flag_q <= 1'b0;
         output_clock_pos_q <= 1'b0;
         output_clock_neg_q <= 1'b1;
         enc_hist_q <= 3'h0;
         ph_hist_q <= 2'h0;
      end else begin
         enc_hist_q <= {enc_hist_q[1:0], enc_level};
         ph_hist_q <= phase_q;
         if (sleep_q) begin
            output_clock_pos_q <= 1'b0;
            output_clock_neg_q <= 1'b1;
         end else begin
            output_clock_pos_q <= clk_src;
            output_clock_neg_q <= !clk_src;
            if (conv_start) begin
               held_q <= core_sample;
               held_rng_q <= core_range;
            end
            if (!is_ddr && enc_fall) begin
               sample_bits_q <= held_q;
               range_flag_q <= held_rng_q;
            end
            if (is_ddr && enc_fall) begin
               ddr_pair_lines_q <= even_bits;
               range_flag_q <= held_rng_q;
            end
            if (is_ddr && conv_start) begin
               ddr_pair_lines_q <= odd_bits;
            end
         end
      end
   end
   wire unused_misc = unused_sdo | ph_hist_q[0];
endmodule // acfg_top

// *** inc/acfg_defs.vh ***
`ifndef ACFG_DEFS_VH
`define ACFG_DEFS_VH
// Sample and frame widths
`define ACFG_SAMPLE_W 14
`define ACFG_PAIR_N 7
`define ACFG_FRAME_W 16
`define ACFG_ADDR_W 7
`define ACFG_ADDR_MSB 14
`define ACFG_ADDR_LSB 8
`define ACFG_RW_BIT 15
`define ACFG_DATA_W 8
`define ACFG_BIT_CNT_W 5
`define ACFG_BIT_LAST 5'h0f
`define ACFG_BIT_DATA0 5'h08
`define ACFG_REG_N 5
`define ACFG_REG_AW 3
// Register indices
`define ACFG_REG_RESET 3'h0
`define ACFG_REG_POWER 3'h1
`define ACFG_REG_TIMING 3'h2
`define ACFG_REG_OUTMODE 3'h3
`define ACFG_REG_DATAFMT 3'h4
// Field positions
`define ACFG_F_SOFT_RESET 7
`define ACFG_F_SLEEP 0
`define ACFG_F_DCS 0
`define ACFG_F_PHASE_LSB 1
`define ACFG_F_PHASE_MSB 2
`define ACFG_F_MODE_LSB 0
`define ACFG_F_MODE_MSB 1
`define ACFG_F_TERM 2
`define ACFG_F_ILVDS_LSB 4
`define ACFG_F_ILVDS_MSB 6
// Output modes
`define ACFG_MODE_CMOS 2'h0
`define ACFG_MODE_DDR_CMOS 2'h1
`define ACFG_MODE_DDR_LVDS 2'h2
// Reset values
`define ACFG_REG_RST 8'h00
// LVDS current code for the 3.5mA setting
`define ACFG_ILVDS_3P5 3'h0
`define ACFG_PHASE_0 2'h0
`endif

// *** verilog/acfg_regfile.v ***
`timescale 1ns/1ns
`include "acfg_defs.vh"
module acfg_regfile (
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // Write port
   input wire wr_en,
   input wire [`ACFG_REG_AW-1:0] wr_addr,
   input wire [`ACFG_DATA_W-1:0] wr_data,
   input wire clear_all,
   // Read port, registered
   input wire [`ACFG_REG_AW-1:0] rd_addr,
   output reg [`ACFG_DATA_W-1:0] rd_data_q,
   // Flat view of all registers
   output wire [`ACFG_REG_N*`ACFG_DATA_W-1:0] regs_flat
);
   reg [`ACFG_DATA_W-1:0] mem_q [0:`ACFG_REG_N-1];
   genvar gi;
   generate
      for (gi = 0; gi < `ACFG_REG_N; gi = gi + 1) begin : g_reg
         always @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
               mem_q[gi] <= `ACFG_REG_RST;
            end else if (clear_all) begin
               mem_q[gi] <= `ACFG_REG_RST;
            end else if (wr_en && wr_addr == gi) begin
               mem_q[gi] <= wr_data;
            end
         end
         assign regs_flat[gi*`ACFG_DATA_W +: `ACFG_DATA_W] = mem_q[gi];
      end
   endgenerate
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data_q <= `ACFG_REG_RST;
      end else if (rd_addr < `ACFG_REG_N) begin
         rd_data_q <= mem_q[rd_addr];
      end else begin
         rd_data_q <= `ACFG_REG_RST;
      end
   end
endmodule // acfg_regfile

// *** bench/acfg_props.sv ***
`timescale 1ns/1ns
`include "acfg_defs.vh"
module acfg_props (
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // Pins
   input wire programming_select,
   input wire cs_n,
   input wire sck,
   input wire sdi,
   // Outputs
   input wire sdo_out_q,
   input wire sdo_oe_q,
   input wire [`ACFG_SAMPLE_W-1:0] sample_bits_q,
   input wire [`ACFG_PAIR_N-1:0] ddr_pair_lines_q,
   input wire range_flag_q,
   input wire output_clock_pos_q,
   input wire output_clock_neg_q,
   input wire [1:0] out_mode_q,
   input wire dcs_enable_q,
   input wire sleep_q,
   input wire [2:0] lvds_current_q
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   property p_clk_inv;
      out_mode_q != `ACFG_MODE_DDR_LVDS |-> output_clock_neg_q == !output_clock_pos_q;
   endproperty
   a_clk_inv: assert property (p_clk_inv) else $error("negative clock not inverse");
   property p_strap_dcs;
      (programming_select && $stable(cs_n))[*8] |-> dcs_enable_q == cs_n;
   endproperty
   a_strap_dcs: assert property (p_strap_dcs) else $error("strapped stabilizer wrong");
   property p_strap_mode;
      (programming_select && $stable(sck))[*8] |-> lvds_current_q == `ACFG_ILVDS_3P5
         && out_mode_q == (sck ? `ACFG_MODE_DDR_LVDS : `ACFG_MODE_CMOS);
   endproperty
   a_strap_mode: assert property (p_strap_mode) else $error("strapped mode wrong");
   property p_strap_sleep;
      (programming_select && $stable(sdi))[*8] |-> sleep_q == sdi;
   endproperty
   a_strap_sleep: assert property (p_strap_sleep) else $error("strapped sleep wrong");
   property p_strap_sdo;
      programming_select[*8] |-> !sdo_oe_q && !sdo_out_q;
   endproperty
   a_strap_sdo: assert property (p_strap_sdo) else $error("data output driven");
   property p_cmos_edge;
      programming_select && out_mode_q == `ACFG_MODE_CMOS && $stable(out_mode_q) && !$past(sleep_q, 2)
         && ($changed(sample_bits_q) || $changed(range_flag_q)) |-> $fell(output_clock_pos_q);
   endproperty
   a_cmos_edge: assert property (p_cmos_edge) else $error("data change off clock fall");
   property p_ddr_edge;
      programming_select && out_mode_q == `ACFG_MODE_DDR_LVDS && $stable(out_mode_q) && !$past(sleep_q, 2)
         && $changed(ddr_pair_lines_q) |-> $changed(output_clock_pos_q);
   endproperty
   a_ddr_edge: assert property (p_ddr_edge) else $error("pair change off clock edge");
   property p_cs_gate;
      (!programming_select && cs_n)[*8] |-> $stable(out_mode_q) && $stable(sleep_q) && $stable(dcs_enable_q);
   endproperty
   a_cs_gate: assert property (p_cs_gate) else $error("setting changed while deselected");
endmodule // acfg_props
bind acfg_top acfg_props u_props (.sys_clk, .reset_n, .programming_select, .cs_n, .sck, .sdi, .sdo_out_q,
   .sdo_oe_q, .sample_bits_q, .ddr_pair_lines_q, .range_flag_q, .output_clock_pos_q, .output_clock_neg_q,
   .out_mode_q, .dcs_enable_q, .sleep_q, .lvds_current_q);

// *** bench/acfg_spi_master.sv ***
`timescale 1ns/1ns
module acfg_spi_master (
   // Clock
   input wire sys_clk,
   // Serial pins
   output logic cs_n,
   output logic sck,
   output logic sdi,
   input wire sdo
);
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      sdi = 1'b0;
   end
   // Half of a 48 ns serial clock period
   task automatic half();
      repeat (6) @(negedge sys_clk);
   endtask
   // Static levels; the data output is ignored
   task automatic strap(input logic c, input logic k, input logic d);
      @(negedge sys_clk);
      cs_n = c;
      sck = k;
      sdi = d;
   endtask
   // One frame, MSB first; readback taken before each of the last eight falls
   task automatic xfer(input logic [15:0] f, input logic gate, output logic [7:0] rd);
      rd = 8'h00;
      @(negedge sys_clk);
      cs_n = gate;
      for (int n = 0; n < 16; n++) begin
         if (n >= 9)
            rd = {rd[6:0], sdo};
         sck = 1'b0;
         sdi = f[15-n];
         half();
         sck = 1'b1;
         half();
      end
      rd = {rd[6:0], sdo};
      sck = 1'b0;
      half();
      cs_n = 1'b1;
      sdi = ~sdi;
      half();
   endtask
endmodule // acfg_spi_master

// *** bench/acfg_top_bench.sv ***
`timescale 1ns/1ns
`include "acfg_defs.vh"
module acfg_top_bench;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic programming_select = 1'b1;
   logic encode_pos = 1'b0;
   logic [`ACFG_SAMPLE_W-1:0] core_sample = 14'h0000;
   logic core_range = 1'b0;
   logic [7:0] rd;
   int n_fail = 0;
   int n_tests = 0;
   int n;
   wire cs_n, sck, sdi, sdo_out_q, sdo_oe_q, range_flag_q, output_clock_pos_q, output_clock_neg_q;
   wire dcs_enable_q, sleep_q, lvds_term_q;
   wire [`ACFG_SAMPLE_W-1:0] sample_bits_q;
   wire [`ACFG_PAIR_N-1:0] ddr_pair_lines_q;
   wire [1:0] out_mode_q;
   wire [2:0] lvds_current_q;
   wire encode_neg = ~encode_pos;
   // Pull-up on the open-drain line
   wire sdo_in = sdo_oe_q ? 1'b0 : 1'b1;
   acfg_spi_master m (.sys_clk, .cs_n, .sck, .sdi, .sdo(sdo_in));
   acfg_top dut (.sys_clk, .reset_n, .programming_select, .cs_n, .sck, .sdi, .sdo_in, .sdo_out_q, .sdo_oe_q,
      .encode_pos, .encode_neg, .core_sample, .core_range, .sample_bits_q, .ddr_pair_lines_q, .range_flag_q,
      .output_clock_pos_q, .output_clock_neg_q, .out_mode_q, .dcs_enable_q, .sleep_q, .lvds_current_q,
      .lvds_term_q);
   initial forever #2 sys_clk = ~sys_clk;
   initial forever #32 encode_pos = ~encode_pos;
   task automatic clk(input int c);
      repeat (c) @(negedge sys_clk);
   endtask
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize();
      if (n_fail == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic put(input logic [13:0] v, input logic r);
      core_sample = v;
      core_range = r;
      clk(48);
   endtask
   task automatic wait_pos(input logic v);
      for (int i = 0; i < 40 && output_clock_pos_q === v; i++) clk(1);
      for (int i = 0; i < 40 && output_clock_pos_q !== v; i++) clk(1);
      clk(2);
   endtask
   // Sample 2A5C: even bits give 0E, odd bits 72
   task automatic ddr_chk();
      put(14'h2a5c, 1'b0);
      wait_pos(1'b0);
      cmp("ddr even", 16'h000e, ddr_pair_lines_q);
      wait_pos(1'b1);
      cmp("ddr odd", 16'h0072, ddr_pair_lines_q);
   endtask
   task automatic t_strap();
      for (int i = 0; i < 8; i++) begin
         m.strap(i[2], i[1], i[0]);
         clk(12);
         cmp("straps", {i[2], i[1] ? `ACFG_MODE_DDR_LVDS : `ACFG_MODE_CMOS, `ACFG_ILVDS_3P5, 2'h0, i[0], 1'b0},
            {dcs_enable_q, out_mode_q, lvds_current_q, lvds_term_q, 1'b0, sleep_q, sdo_oe_q});
      end
      m.strap(1'b1, 1'b0, 1'b0);
      put(14'h2a5c, 1'b1);
      cmp("cmos sample", {1'b1, 14'h2a5c}, {range_flag_q, sample_bits_q});
      put(14'h15a3, 1'b0);
      cmp("cmos sample", {1'b0, 14'h15a3}, {range_flag_q, sample_bits_q});
      m.strap(1'b1, 1'b1, 1'b0);
      ddr_chk();
   endtask
   task automatic t_serial();
      m.strap(1'b1, 1'b0, 1'b0);
      programming_select = 1'b0;
      clk(12);
      m.xfer(16'h0355, 1'b0, rd);
      clk(4);
      cmp("outmode", 16'h001d, {out_mode_q, lvds_term_q, lvds_current_q});
      ddr_chk();
      m.xfer(16'h8300, 1'b0, rd);
      cmp("readback", 16'h0055, rd);
      m.xfer(16'h0300, 1'b1, rd);
      clk(4);
      cmp("gated mode", 16'h0001, out_mode_q);
      m.xfer(16'h06a5, 1'b0, rd);
      m.xfer(16'h8600, 1'b0, rd);
      cmp("unmapped read", 16'h0000, rd);
      m.xfer(16'h0101, 1'b0, rd);
      m.xfer(16'h0201, 1'b0, rd);
      clk(4);
      cmp("sleep dcs", 16'h0003, {sleep_q, dcs_enable_q});
      m.xfer(16'h0100, 1'b0, rd);
      m.xfer(16'h0300, 1'b0, rd);
      m.xfer(16'h0205, 1'b0, rd);
      core_sample = 14'h1234;
      for (int i = 0; i < 40 && sample_bits_q !== 14'h1234; i++) clk(1);
      for (n = 0; n < 8 && output_clock_pos_q !== 1'b0; n++) clk(1);
      cmp("clock lag", 16'h0002, n[15:0]);
      m.xfer(16'h0080, 1'b0, rd);
      clk(4);
      cmp("soft reset", 16'h0000, {out_mode_q, sleep_q, dcs_enable_q});
   endtask
   initial begin
      #200000;
      n_fail++;
      summarize();
   end
   initial begin
      clk(10);
      cmp("reset outputs", 16'h0001, {sdo_oe_q, range_flag_q, output_clock_pos_q, sample_bits_q != 0, out_mode_q,
         output_clock_neg_q});
      clk(6);
      reset_n = 1'b1;
      clk(4);
      t_strap();
      t_serial();
      summarize();
   end
endmodule // acfg_top_bench
